/* pet_fw_model.sv */
`timescale 1ns/1ps
// Firmware side: single-cycle register strobes, never waits
module pet_fw_model
   import pet_pkg::*;
(
   input wire logic clk_sys,
   output pet_req_t req,
   input wire logic [CNT_W-1:0] rd_data
);
   // Bus idle from time zero
   initial req = '0;

   // Write strobe held for exactly one edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d);
      @(posedge clk_sys);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      req <= '0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [CNT_W-1:0] d);
      @(posedge clk_sys);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk_sys);
      req <= '0;
      #1;
      d = rd_data;
   endtask
endmodule

/* pet_pkg.sv */
package pet_pkg;
   // Bank sizes
   localparam int EVT_N = 8;
   localparam int EVT_W = 3;
   localparam int DO_N = 8;
   localparam int SEC_N = 4;
   localparam int CNT_W = 32;
   localparam int ADDR_W = 8;

   // Counter numbering and the block of counters that never pulse
   localparam int EVT_FIRST = 50;
   localparam int NO_PULSE_LO = 51;
   localparam int NO_PULSE_HI = 54;

   // Time base
   localparam int CLK_NS = 50;
   localparam int TICK_100_NS = 10_000_000;
   localparam int PRE_CYC_DEF = TICK_100_NS / CLK_NS;
   localparam int PRE_W = 18;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] A_PMAP = 8'h04;
   localparam logic [ADDR_W-1:0] A_EST = 8'h08;
   localparam logic [ADDR_W-1:0] A_LVL = 8'h0c;
   localparam logic [ADDR_W-1:0] A_SEN = 8'h10;
   localparam logic [1:0] R_EVT = 2'h1;
   localparam logic [1:0] R_INC = 2'h2;
   localparam logic [1:0] R_SEC = 2'h3;
   localparam int CTRL_RUN = 0;

   // Reset values
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [CNT_W-1:0] wdata;
   } pet_req_t;

   typedef struct packed {
      logic valid;
      logic [EVT_W-1:0] idx;
   } pet_pair_t;

   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic t100;
      logic t50;
      logic half;
      logic run;
      logic [DO_N-1:0] pmap;
      logic [EVT_N-1:0] est;
      logic [DO_N-1:0] lvl;
      logic [SEC_N-1:0] sen;
      logic [EVT_N-1:0][CNT_W-1:0] evt;
      logic [SEC_N-1:0][CNT_W-1:0] sec;
      logic [CNT_W-1:0] rdata;
   } pet_state_t;
endpackage

/* pet_timer.sv */
`timescale 1ns/1ps
module pet_timer
   import pet_pkg::*;
#(
   parameter int PRE_CYC = PRE_CYC_DEF
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire pet_req_t req,
   output logic [CNT_W-1:0] rd_data,
   output logic [DO_N-1:0] pulse_do
);

   pet_state_t st;
   pet_state_t next_st;
   logic [EVT_N-1:0] ldnz;
   logic [EVT_N-1:0] hit;
   logic [EVT_N-1:0] chg;

   // Pair a pulse output with its counter, offset from the first pulse output
   function automatic pet_pair_t pair_of(input logic [DO_N-1:0] pmap,
                                         input int d);
      pet_pair_t p;
      int first;
      int off;
      p.valid = 1'b0;
      p.idx = '0;
      first = DO_N;
      for (int k = DO_N - 1; k >= 0; k--)
      begin
         if (pmap[k])
            first = k;
      end
      off = d - first;
      if (pmap[d] && off >= 0 && off < EVT_N &&
          !(EVT_FIRST + off >= NO_PULSE_LO &&
            EVT_FIRST + off <= NO_PULSE_HI))
      begin
         p.valid = 1'b1;
         p.idx = EVT_W'(off);
      end
      return p;
   endfunction

   // Word index of a windowed register within its region
   function automatic int win_idx(input logic [ADDR_W-1:0] a);
      return int'(a[5:2]);
   endfunction

   // Next state
   always_comb
   begin
      pet_pair_t p;
      int k;
      p = '0;
      k = 0;
      next_st = st;
      next_st.t100 = 1'b0;
      next_st.t50 = 1'b0;
      next_st.rdata = '0;
      ldnz = '0;
      hit = '0;
      chg = '0;

      // Ticks are one-cycle strobes, so counters need no second clock
      // Prescaler: 100 Hz tick, every second one is the 50 Hz tick
      if (st.pre == PRE_W'(PRE_CYC - 1))
      begin
         next_st.pre = '0;
         next_st.t100 = 1'b1;
         next_st.half = ~st.half;
         next_st.t50 = st.half;
      end
      else
      begin
         next_st.pre = st.pre + PRE_W'(1);
      end

      // Count down in either state, stop at zero instead of wrapping
      for (int i = 0; i < EVT_N; i++)
      begin
         if (st.t50 && st.evt[i] != CNT_RST)
         begin
            next_st.evt[i] = st.evt[i] - CNT_ONE;
            hit[i] = (st.evt[i] == CNT_ONE);
         end
      end

      // Seconds timers in hundredths, only when enabled and running
      for (int j = 0; j < SEC_N; j++)
      begin
         if (st.t100 && st.run && st.sen[j])
            next_st.sec[j] = st.sec[j] + CNT_ONE;
      end

      // A load or bump in a tick cycle drops that tick for that counter
      // Register writes; a write beats the tick in the same cycle
      k = win_idx(req.addr);
      if (req.wr)
      begin
         if (req.addr == A_CTRL)
            next_st.run = req.wdata[CTRL_RUN];
         else if (req.addr == A_PMAP)
            next_st.pmap = req.wdata[DO_N-1:0];
         else if (req.addr == A_EST)
         begin
            next_st.est = req.wdata[EVT_N-1:0];
            for (int i = 0; i < EVT_N; i++)
               chg[i] = (req.wdata[i] != st.est[i]) &&
                        (st.evt[i] != CNT_RST);
         end
         else if (req.addr == A_SEN)
            next_st.sen = req.wdata[SEC_N-1:0];
         else if (req.addr[7:6] == R_EVT && k < EVT_N)
         begin
            next_st.evt[k] = req.wdata;
            ldnz[k] = (req.wdata != CNT_RST);
            hit[k] = 1'b0;
         end
         else if (req.addr[7:6] == R_INC && k < EVT_N)
         begin
            next_st.evt[k] = st.evt[k] + CNT_ONE;
            hit[k] = 1'b0;
         end
         else if (req.addr[7:6] == R_SEC && k < SEC_N)
            next_st.sec[k] = req.wdata;
      end

      // Later branches win: a zero hit in a flip cycle follows the new state
      // Pulse output levels from their paired counters
      for (int d = 0; d < DO_N; d++)
      begin
         p = pair_of(st.pmap, d);
         if (p.valid)
         begin
            if (chg[p.idx])
               next_st.lvl[d] = next_st.est[p.idx];
            if (ldnz[p.idx])
               next_st.lvl[d] = st.est[p.idx];
            if (hit[p.idx])
               next_st.lvl[d] = ~next_st.est[p.idx];
         end
         else
         begin
            next_st.lvl[d] = 1'b0;
         end
      end

      // Register reads, answered in the next cycle; unmapped reads zero
      if (req.rd)
      begin
         if (req.addr == A_CTRL)
            next_st.rdata[CTRL_RUN] = st.run;
         else if (req.addr == A_PMAP)
            next_st.rdata[DO_N-1:0] = st.pmap;
         else if (req.addr == A_EST)
            next_st.rdata[EVT_N-1:0] = st.est;
         else if (req.addr == A_LVL)
            next_st.rdata[DO_N-1:0] = st.lvl;
         else if (req.addr == A_SEN)
            next_st.rdata[SEC_N-1:0] = st.sen;
         else if (req.addr[7:6] == R_EVT && k < EVT_N)
            next_st.rdata = st.evt[k];
         else if (req.addr[7:6] == R_SEC && k < SEC_N)
            next_st.rdata = st.sec[k];
      end
   end

   // Async clear leaves every output at its idle, all-zero level
   // State register
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         st <= '0;
      else
         st <= next_st;
   end

   // Outputs straight from flops
   assign rd_data = st.rdata;
   assign pulse_do = st.lvl;

   // Checks on counter 0 paired with output 0 (counter 50), counter 1, outputs 1 to 4, the ticks and seconds timer 0
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   load_off_a: assert property (
      st.pmap[0] && !st.est[0] && req.wr && req.addr == {R_EVT, 6'h00}
      && req.wdata != CNT_RST |=> !pulse_do[0])
      else $error("off-state load did not turn output off");

   load_on_a: assert property (
      st.pmap[0] && st.est[0] && req.wr && req.addr == {R_EVT, 6'h00}
      && req.wdata != CNT_RST |=> pulse_do[0])
      else $error("on-state load did not turn output on");

   zero_hit_a: assert property (
      st.pmap[0] && st.t50 && st.evt[0] == CNT_ONE && !req.wr
      |=> pulse_do[0] == ~st.est[0] && st.evt[0] == CNT_RST)
      else $error("output did not flip when count reached zero");

   hold_zero_a: assert property (
      st.evt[0] == CNT_RST && !req.wr |=> st.evt[0] == CNT_RST)
      else $error("zero counter moved without a write");

   count_down_a: assert property (
      st.t50 && st.evt[1] != CNT_RST && !req.wr
      |=> st.evt[1] == $past(st.evt[1]) - CNT_ONE)
      else $error("counter missed a tick");

   no_pulse_a: assert property (
      st.pmap[0] && !req.wr |=> st.lvl[4:1] == 4'h0)
      else $error("counters 51 to 54 drove an output");

   bump_zero_a: assert property (
      st.pmap[0] && st.evt[0] == CNT_RST && req.wr && req.addr == A_EST
      |=> $stable(st.lvl[0]))
      else $error("state flip at zero moved output");

   bump_move_a: assert property (
      st.pmap[0] && st.evt[0] > CNT_ONE && req.wr && req.addr == A_EST
      && req.wdata[0] != st.est[0] |=> st.lvl[0] == $past(req.wdata[0]))
      else $error("state flip did not move output");

   sec_run_a: assert property (
      st.t100 && st.run && st.sen[0] && !req.wr
      |=> st.sec[0] == $past(st.sec[0]) + CNT_ONE)
      else $error("seconds timer did not advance");

   sec_hold_a: assert property (
      !(st.run && st.sen[0]) && !req.wr |=> $stable(st.sec[0]))
      else $error("stopped seconds timer moved");

   tick_rel_a: assert property (
      st.t50 |-> st.t100 ##1 !st.t100 && !st.t50)
      else $error("ticks misaligned");

   // Pairing by offset, register answers and seconds-timer corners
   pair_move_a: assert property (
      st.pmap[2] && st.pmap[1:0] == 2'h0 && st.est[0] && req.wr
      && req.addr == {R_EVT, 6'h00} && req.wdata != CNT_RST
      |=> pulse_do[2])
      else $error("offset output did not follow its counter");

   unpaired_low_a: assert property (
      !st.pmap[0] |=> !pulse_do[0])
      else $error("unpaired output was driven");

   tick_step_a: assert property (
      !st.t50 && !req.wr |=> $stable(st.evt[1]))
      else $error("counter moved between ticks");

   bump_up_a: assert property (
      req.wr && req.addr == {R_INC, 6'h04}
      |=> st.evt[1] == $past(st.evt[1]) + CNT_ONE)
      else $error("increment write did not add one");

   read_idle_a: assert property (
      !req.rd |=> rd_data == CNT_RST)
      else $error("read data stood without a read");

   read_count_a: assert property (
      req.rd && req.addr == {R_EVT, 6'h00}
      |=> rd_data == $past(st.evt[0]))
      else $error("counter read gave wrong value");

   est_read_a: assert property (
      req.rd && req.addr == A_EST
      |=> rd_data[EVT_N-1:0] == $past(st.est))
      else $error("state read gave wrong value");

   sec_wrap_a: assert property (
      st.t100 && st.run && st.sen[0] && st.sec[0] == '1 && !req.wr
      |=> st.sec[0] == CNT_RST)
      else $error("seconds timer did not wrap to zero");

   sec_load_a: assert property (
      req.wr && req.addr == {R_SEC, 6'h00}
      |=> st.sec[0] == $past(req.wdata))
      else $error("seconds timer preset lost");

   sec_read_a: assert property (
      req.rd && req.addr == {R_SEC, 6'h00}
      |=> rd_data == $past(st.sec[0]))
      else $error("seconds timer read gave wrong value");

   pulse_cv: cover property (st.pmap[0] && st.t50 && st.evt[0] == CNT_ONE);
   bump_cv: cover property (st.pmap[0] && req.wr && req.addr == A_EST
      && st.evt[0] > CNT_ONE);
   sec_cv: cover property (st.t100 && st.run && st.sen[0]);
   wrap_cv: cover property (st.t100 && st.run && st.sen[0]
      && st.sec[0] == '1);
   pair_cv: cover property (st.pmap[2] && !st.pmap[0] && pulse_do[2]);

endmodule

/* tb_pulse_output_event_timer.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_pulse_output_event_timer;
   import pet_pkg::*;
   // Short prescale: 100 Hz tick every 4 cycles, 50 Hz every 8
   localparam int PRE = 4;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   pet_req_t req;
   logic [CNT_W-1:0] rd_data;
   logic [CNT_W-1:0] v;
   logic [DO_N-1:0] pulse_do;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;

   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;

   pet_timer #(.PRE_CYC(PRE)) pet_timer_inst (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .req(req), .rd_data(rd_data), .pulse_do(pulse_do));
   pet_fw_model pet_fw_model_inst (.clk_sys(clk_sys), .req(req),
      .rd_data(rd_data));

   task automatic tally_and_finish();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard, far above the roughly 730 cycles the tests need
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      pet_fw_model_inst.wr(a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      pet_fw_model_inst.rd(a, v);
   endtask
   // Change of a register across exactly 80 edges (ten 50 Hz ticks)
   task automatic span(input logic [7:0] a, output logic [31:0] d);
      logic [31:0] s;
      rd(a);
      s = v;
      cyc(78);
      rd(a);
      d = v - s;
   endtask

   task automatic t_reset();
      rd(A_CTRL);
      `CHK(v, CNT_RST)
      rd(8'h40);
      `CHK(v, CNT_RST)
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20);
      `CHK(v, CNT_RST)
      `CHK(pulse_do, 8'h00)
      $display("reset done");
   endtask

   task automatic t_pulse();
      wr(A_PMAP, 32'h0000_0001);
      wr(A_EST, 32'h0000_0001);
      wr(8'h40, 32'h0000_0003);
      cyc(1);
      `CHK(pulse_do[0], 1'b1)
      cyc(40);
      `CHK(pulse_do[0], 1'b0)
      rd(8'h40);
      `CHK(v, CNT_RST)
      wr(A_EST, 32'h0000_0000);
      wr(8'h40, 32'h0000_0002);
      cyc(1);
      `CHK(pulse_do[0], 1'b0)
      cyc(40);
      `CHK(pulse_do[0], 1'b1)
      wr(8'h40, 32'h0000_0002);
      cyc(1);
      `CHK(pulse_do[0], 1'b0)
      cyc(40);
      `CHK(pulse_do[0], 1'b1)
      wr(A_EST, 32'h0000_0001);
      cyc(1);
      `CHK(pulse_do[0], 1'b1)
      wr(8'h40, 32'h0000_00c8);
      wr(A_EST, 32'h0000_0000);
      cyc(1);
      `CHK(pulse_do[0], 1'b0)
      wr(A_EST, 32'h0000_0001);
      cyc(1);
      `CHK(pulse_do[0], 1'b1)
      rd(A_LVL);
      `CHK(v, 32'h0000_0001)
      $display("pulse done");
   endtask

   task automatic t_rate();
      span(8'h40, v);
      `CHK(v, 32'hffff_fff6)
      wr(A_EST, 32'h0000_0000);
      span(8'h40, v);
      `CHK(v, 32'hffff_fff6)
      wr(8'h44, 32'h0000_1000);
      wr(8'h84, 32'h0000_0000);
      rd(8'h44);
      `CHK(v == 32'h0000_1001 || v == 32'h0000_1000, 1'b1)
      $display("rate done");
   endtask

   task automatic t_pair();
      wr(A_PMAP, 32'h0000_003f);
      wr(A_EST, 32'h0000_00ff);
      for (int i = 1; i < 6; i++)
         wr(8'h40 + 8'(4 * i), 32'h0000_0032);
      cyc(2);
      `CHK(pulse_do[5:1], 5'h10)
      wr(A_PMAP, 32'h0000_0004);
      wr(8'h40, 32'h0000_0032);
      cyc(2);
      `CHK(pulse_do, 8'h04)
      rd(A_PMAP);
      `CHK(v, 32'h0000_0004)
      rd(A_EST);
      `CHK(v, 32'h0000_00ff)
      $display("pair done");
   endtask

   task automatic t_sec();
      wr(A_SEN, 32'h0000_0001);
      rd(A_SEN);
      `CHK(v, 32'h0000_0001)
      span(8'hc0, v);
      `CHK(v, CNT_RST)
      wr(A_CTRL, 32'h0000_0001);
      rd(A_CTRL);
      `CHK(v, 32'h0000_0001)
      span(8'hc0, v);
      `CHK(v, 32'h0000_0014)
      wr(A_SEN, 32'h0000_0000);
      span(8'hc0, v);
      `CHK(v, CNT_RST)
      wr(A_SEN, 32'h0000_0001);
      wr(8'hc0, 32'hffff_fff0);
      cyc(100);
      rd(8'hc0);
      `CHK(v[31:4], 28'h000_0000)
      $display("seconds done");
   endtask

   // Reset for 12 cycles, then the scenarios in order
   initial
   begin
      cyc(12);
      sys_rst <= 1'b0;
      t_reset();
      t_pulse();
      t_rate();
      t_pair();
      t_sec();
      tally_and_finish();
   end
endmodule
